// *** hw/pmi_pkg.sv ***
// shared constants and carrier types for the port 0 input side
package pmi_pkg;
  // core clock and reference clock periods, in nanoseconds
  localparam int CORE_PERIOD_NS = 4;
  localparam int MII_REF_PERIOD_NS = 40;
  localparam int RMII_REF_PERIOD_NS = 20;
  // reference periods counted in core clock cycles
  localparam int MII_DIV_CYC = MII_REF_PERIOD_NS / CORE_PERIOD_NS;
  localparam int RMII_DIV_CYC = RMII_REF_PERIOD_NS / CORE_PERIOD_NS;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
  localparam logic [DIV_W-1:0] MII_DIV_LAST = DIV_W'(MII_DIV_CYC - 1);
  localparam logic [DIV_W-1:0] RMII_DIV_LAST = DIV_W'(RMII_DIV_CYC - 1);
  localparam logic [DIV_W-1:0] MII_DIV_HALF = DIV_W'(MII_DIV_CYC / 2);
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] DIBIT_PAD = 2'h0;

  // port personality
  typedef enum logic [1:0] {
    PMI_MAC = 2'b00,
    PMI_PHY = 2'b01,
    PMI_RMII_PHY = 2'b11
  } pmi_mode_t;

  // one nibble (or dibit) handed to the switch port
  typedef struct packed {
    logic [NIB_W-1:0] dat;
    logic dibit;
    logic rx_err;
    logic abort;
    logic last;
  } pmi_word_t;

  localparam int WORD_W = $bits(pmi_word_t);

  // raw pin group as seen through the input buffers
  typedef struct packed {
    logic [NIB_W-1:0] dat;
    logic valid;
    logic err;
    logic clk;
  } pmi_pins_t;
endpackage

// *** hw/pmi_port_in.sv ***
// port 0 media-independent input side: pin capture, framing and word fifo
`timescale 1ns/1ns
`default_nettype none

module pmi_fifo
  import pmi_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } pmi_fifo_st_t;

  pmi_fifo_st_t s_reg;
  pmi_fifo_st_t s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // output word sits in a register so the top sees flop outputs only
  always_comb
  begin
    s_next = s_reg;
    in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
    push = in_valid && in_ready;
    pop = (s_reg.cnt != '0) && (!s_reg.ov || out_ready);
    if (out_ready && s_reg.ov)
    begin
      s_next.ov = 1'b0;
    end
    if (pop)
    begin
      s_next.od = mem[s_reg.rd_ptr];
      s_next.ov = 1'b1;
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
    if (push)
    begin
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    out_valid = s_reg.ov;
    out_data = s_reg.od;
  end

  // storage has no reset; only pointers and count matter
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[s_reg.wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule

module pmi_port_in
  import pmi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire pmi_mode_t port_mode,
  input wire logic port_isolate_bit,
  input wire logic in_data_bit3,
  input wire logic in_data_bit2,
  input wire logic in_data_bit1,
  input wire logic in_data_bit0,
  input wire logic in_data_valid,
  input wire logic in_data_error,
  input wire logic in_ref_clock_i,
  output logic in_ref_clock_o,
  output logic in_ref_clock_oe_n,
  output logic in_pulldown_en,
  output logic in_buffer_en,
  output logic out_valid,
  input wire logic out_ready,
  output pmi_word_t out_word,
  output logic overflow
);
  typedef struct packed {
    pmi_pins_t pin_s1;
    pmi_pins_t pin_s2;
    logic clk_s3;
    logic [DIV_W-1:0] div;
    logic ref_out;
    logic ref_oe_n;
    logic pd_en;
    logic buf_en;
    pmi_word_t held;
    logic held_v;
    logic err_acc;
    logic dropping;
    pmi_word_t push_word;
    logic push_v;
    logic overflow;
  } pmi_state_t;

  pmi_state_t s_reg;
  pmi_state_t s_next;
  logic fifo_ready;
  logic [WORD_W-1:0] fifo_out;
  logic is_phy;
  logic is_rmii;
  logic is_mac;
  logic iso;
  logic tick;
  logic v;
  logic e;
  logic abort_now;
  logic [NIB_W-1:0] d;
  logic [DIV_W-1:0] div_last;
  pmi_pins_t pins;
  always_comb
  begin
    s_next = s_reg;
    is_mac = (port_mode == PMI_MAC);
    is_rmii = (port_mode == PMI_RMII_PHY);
    is_phy = !is_mac;
    iso = port_isolate_bit && is_phy;
    // raw pins pass two flops first; a disabled input buffer then reads as low
    s_next.pin_s1 = {in_data_bit3, in_data_bit2, in_data_bit1, in_data_bit0,
                     in_data_valid, in_data_error, in_ref_clock_i};
    s_next.pin_s2 = s_reg.pin_s1;
    pins = pmi_pins_t'(s_reg.pin_s2 & {7{s_reg.buf_en}});
    s_next.clk_s3 = pins.clk;
    s_next.buf_en = !iso;
    s_next.pd_en = !iso;
    // reference timing: external clock edge in mac mode, own divider otherwise
    div_last = is_rmii ? RMII_DIV_LAST : MII_DIV_LAST;
    if (is_mac || s_reg.div >= div_last)
    begin
      s_next.div = DIV_ZERO;
    end
    else
    begin
      s_next.div = s_reg.div + 1'b1;
    end
    // current count keeps the first period after reset whole; rises the second edge after a tick
    s_next.ref_out = (port_mode == PMI_PHY) && (s_reg.div < MII_DIV_HALF);
    s_next.ref_oe_n = !((port_mode == PMI_PHY) && !port_isolate_bit);
    if (is_mac)
    begin
      tick = pins.clk && !s_reg.clk_s3;
    end
    else
    begin
      tick = (s_reg.div == div_last);
    end
    // qualify pins; isolate kills valid and error even in mac mode
    v = pins.valid && !port_isolate_bit;
    e = pins.err && v && !is_rmii;
    d = is_rmii ? {DIBIT_PAD, pins.dat[1:0]} : pins.dat;
    abort_now = e && (port_mode == PMI_PHY);
    // one nibble is held back so the frame end can be flagged on it
    s_next.push_v = 1'b0;
    if (tick)
    begin
      if (s_reg.held_v)
      begin
        s_next.push_word = s_reg.held;
        s_next.push_word.last = !v || abort_now;
        s_next.push_word.abort = abort_now;
        s_next.push_v = 1'b1;
      end
      s_next.held_v = v && !abort_now && !s_reg.dropping;
      s_next.held.dat = d;
      s_next.held.dibit = is_rmii;
      s_next.held.rx_err = s_reg.err_acc || (e && is_mac);
      s_next.held.abort = 1'b0;
      s_next.held.last = 1'b0;
      s_next.err_acc = v && (s_reg.err_acc || (e && is_mac));
      if (abort_now)
      begin
        s_next.dropping = 1'b1;
      end
      else if (!v)
      begin
        s_next.dropping = 1'b0;
      end
    end
    // pins cannot be stalled: a refused word drops the rest of its frame
    if (s_reg.push_v && !fifo_ready)
    begin
      s_next.overflow = 1'b1;
      s_next.dropping = 1'b1;
      s_next.held_v = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // sixteen word buffer between pin timing and the switch port
  pmi_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(s_reg.push_v),
    .in_ready(fifo_ready),
    .in_data(s_reg.push_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );
  assign out_word = pmi_word_t'(fifo_out);
  assign in_ref_clock_o = s_reg.ref_out;
  assign in_ref_clock_oe_n = s_reg.ref_oe_n;
  assign in_pulldown_en = s_reg.pd_en;
  assign in_buffer_en = s_reg.buf_en;
  assign overflow = s_reg.overflow;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_iso_buffers_off: assert property (iso |=> !in_buffer_en && !in_pulldown_en)
    else $error("input buffers left on while isolated");
  a_iso_no_frame: assert property (port_isolate_bit [*8] |-> !s_reg.held_v && !s_reg.push_v)
    else $error("frame data accepted while isolated");
  a_rmii_low_bits: assert property (s_reg.push_v && s_reg.push_word.dibit |-> s_reg.push_word.dat[3:2] == DIBIT_PAD)
    else $error("upper bits leaked in reduced mode");
  a_phy_abort: assert property (tick && s_reg.held_v && abort_now && fifo_ready
    |=> s_reg.push_v && s_reg.push_word.abort && s_reg.push_word.last)
    else $error("transmit error did not abort packet");
  a_mac_err_mark: assert property (tick && is_mac && e |=> s_reg.held.rx_err)
    else $error("receive error not marked");
  a_valid_gates: assert property (tick && !v |=> !s_reg.held_v)
    else $error("nibble taken without valid");
  a_mac_capture: assert property (tick && is_mac && v && !s_reg.dropping && !(s_reg.push_v && !fifo_ready)
    |=> s_reg.held_v && s_reg.held.dat == $past(s_reg.pin_s2.dat))
    else $error("receive nibble not captured");
  a_phy_capture: assert property (tick && port_mode == PMI_PHY && v && !e && !s_reg.dropping
    && !(s_reg.push_v && !fifo_ready) |=> s_reg.held_v && s_reg.held.dat == $past(s_reg.pin_s2.dat))
    else $error("transmit nibble not captured");
  a_rmii_capture: assert property (tick && is_rmii && v && !s_reg.dropping && !(s_reg.push_v && !fifo_ready)
    |=> s_reg.held.dat[1:0] == $past(s_reg.pin_s2.dat[1:0]) && s_reg.held.dibit)
    else $error("reduced dibit not captured");
  a_phy_ref_drive: assert property ((port_mode == PMI_PHY && !port_isolate_bit) [*2] |-> !in_ref_clock_oe_n)
    else $error("reference clock not driven in phy mode");
  a_phy_ref_period: assert property ((port_mode == PMI_PHY) [*2] ##0 $rose(s_reg.ref_out)
    |-> ##10 (port_mode != PMI_PHY || $rose(s_reg.ref_out)))
    else $error("reference clock period wrong");

  c_abort_seen: cover property (s_reg.push_v && s_reg.push_word.abort);
  c_err_frame: cover property (s_reg.push_v && s_reg.push_word.rx_err && s_reg.push_word.last);
  c_rmii_push: cover property (s_reg.push_v && s_reg.push_word.dibit);
  c_overflow: cover property ($rose(s_reg.overflow));
endmodule

`default_nettype wire

// *** testbench/pmi_far_end.sv ***
// far-end pin model: external phy or mac driving the input pins
`timescale 1ns/1ns
`default_nettype none
module pmi_far_end
  import pmi_pkg::*;
(
  input wire logic core_clk,
  input wire pmi_mode_t mode,
  input wire logic dev_ref_clk,
  output logic ref_clk,
  output logic [3:0] dat,
  output logic valid,
  output logic err
);
  // a phy receive clock runs free at 25 mhz, every edge on a falling edge of the core clock
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  initial {dat, valid, err} = 6'h00;

  // wait for the moment the far end may change its pins
  task automatic step();
    if (mode == PMI_MAC)
      @(negedge ref_clk);
    else if (mode == PMI_PHY)
      @(negedge dev_ref_clk);
    else
      // one dibit per sample tick: the edge below completes the period
      repeat (RMII_DIV_CYC - 1) @(posedge core_clk);
    @(posedge core_clk);
  endtask

  // one frame, then pins fall back to their pull-down level
  task automatic send(input int n, input logic [3:0] base, input int eidx);
    for (int i = 0; i < n; i++)
    begin
      step();
      valid <= 1'b1;
      dat <= base + 4'(i);
      err <= (i == eidx);
    end
    step();
    {dat, valid, err} <= 6'h00;
    repeat (3) step();
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the port 0 input side
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pmi_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  pmi_mode_t port_mode = PMI_MAC;
  pmi_mode_t fe_mode = PMI_MAC;
  logic iso = 1'b0;
  logic out_ready = 1'b1;
  logic ref_o, oe_n, pd_en, buf_en, out_valid, overflow, fe_clk, fe_valid, fe_err;
  logic [3:0] fe_dat;
  pmi_word_t out_word;
  pmi_word_t got[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  // pin level: device drives when enabled, else phy clock or pull-down
  wire logic ref_pin = oe_n ? (fe_clk & (port_mode == PMI_MAC)) : ref_o;

  always #2 core_clk = ~core_clk;

  pmi_port_in DUT (.core_clk(core_clk), .rstn(rstn), .port_mode(port_mode),
    .port_isolate_bit(iso), .in_data_bit3(fe_dat[3]), .in_data_bit2(fe_dat[2]),
    .in_data_bit1(fe_dat[1]), .in_data_bit0(fe_dat[0]), .in_data_valid(fe_valid),
    .in_data_error(fe_err), .in_ref_clock_i(ref_pin), .in_ref_clock_o(ref_o),
    .in_ref_clock_oe_n(oe_n), .in_pulldown_en(pd_en), .in_buffer_en(buf_en),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .overflow(overflow));

  pmi_far_end fe (.core_clk(core_clk), .mode(fe_mode), .dev_ref_clk(ref_o),
    .ref_clk(fe_clk), .dat(fe_dat), .valid(fe_valid), .err(fe_err));

  // gather taken words; cut a hang short
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (out_valid && out_ready)
      got.push_back(out_word);
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // oldest word against {dat, dibit, rx_err, abort, last}
  task automatic pop(input logic [7:0] exp);
    if (got.size() == 0)
      check(8'hxx, exp);
    else
      check(got.pop_front(), exp);
  endtask

  task automatic restart(input pmi_mode_t m, input logic i);
    rstn <= 1'b0;
    port_mode <= m;
    fe_mode <= m;
    iso <= i;
    out_ready <= 1'b1;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic mac_frames();
    restart(PMI_MAC, 1'b0);
    check({7'h00, oe_n}, 8'h01);
    fe.send(4, 4'h3, 99);
    fe.send(4, 4'hA, 2);
    pop(8'h30);
    pop(8'h40);
    pop(8'h50);
    pop(8'h61);
    pop(8'hA0);
    pop(8'hB0);
    pop(8'hC4);
    pop(8'hD5);
  endtask

  task automatic phy_frames();
    restart(PMI_PHY, 1'b0);
    check({5'h00, oe_n, pd_en, buf_en}, 8'h03);
    fe.send(3, 4'h1, 99);
    fe.send(4, 4'h8, 2);
    pop(8'h10);
    pop(8'h20);
    pop(8'h31);
    pop(8'h80);
    pop(8'h93);
    check(8'(got.size()), 8'h00);
  endtask

  task automatic rmii_frame();
    restart(PMI_RMII_PHY, 1'b0);
    check({7'h00, oe_n}, 8'h01);
    fe.send(3, 4'hD, 99);
    pop(8'h18);
    pop(8'h28);
    pop(8'h39);
  endtask

  task automatic isolated();
    restart(PMI_PHY, 1'b1);
    fe_mode <= PMI_MAC;
    @(posedge core_clk);
    check({5'h00, oe_n, pd_en, buf_en}, 8'h04);
    fe.send(3, 4'h5, 1);
    check(8'(got.size()), 8'h00);
    restart(PMI_MAC, 1'b1);
    check({6'h00, pd_en, buf_en}, 8'h03);
    fe.send(3, 4'h5, 1);
    check(8'(got.size()), 8'h00);
  endtask

  // fill the fifo with the switch stalled, then drain it
  task automatic fifo_full();
    restart(PMI_MAC, 1'b0);
    out_ready <= 1'b0;
    fe.send(20, 4'h0, 99);
    check({7'h00, overflow}, 8'h01);
    check({7'h00, out_valid}, 8'h01);
    out_ready <= 1'b1;
    repeat (40) @(posedge core_clk);
    // sixteen stored words plus the one waiting in the output register
    for (int i = 0; i <= FIFO_DEPTH; i++)
      pop({4'(i), 4'h0});
    check(8'(got.size()), 8'h00);
  endtask

  initial
  begin
    mac_frames();
    phy_frames();
    rmii_frame();
    isolated();
    fifo_full();
    end_sim();
  end
endmodule
`default_nettype wire
